// [lcas_map.vh]
// lcas_map.vh: offsets, field positions, reset values and timing counts
// for the per-channel alarm status and transmit control registers.
// assumes an 8-bit parallel microprocessor port with a 4-bit offset.
`ifndef LCAS_MAP_VH
`define LCAS_MAP_VH

// register offsets within the channel
`define LCAS_OFS_STATUS      4'h3
`define LCAS_OFS_TXCTL       4'h4

// status bit positions
`define LCAS_ST_DRIVE_MON    0
`define LCAS_ST_SIG_ABSENT   1
`define LCAS_ST_LOCK_LOST    2
`define LCAS_ST_FIFO_LIMIT   3

// transmit control bit positions
`define LCAS_TC_LEVEL        0
`define LCAS_TC_CLK_INV      1
`define LCAS_TC_ALL_ONES     2
`define LCAS_TC_ERR_INS      4
`define LCAS_TC_MON_INT      5
`define LCAS_TC_WR_MASK      8'h37
`define LCAS_TC_RESET        8'h00

// timing and thresholds in line bit periods
`define LCAS_JA_GUARD        6'h02
`define LCAS_DMO_BITS        8'h80
`define LCAS_DLOS_BITS       8'hA0
`define LCAS_DENS_WIN        8'h60
`define LCAS_DENS_MIN        8'h20
// lock window: 5000 ppm of the count window
`define LCAS_LOCK_WIN        16'h0FA0
`define LCAS_LOCK_TOL        16'h0014

`endif

// [lcas_activity_monitor.v]
// lcas_activity_monitor.v: counts bit periods with no pulse and raises
// an alarm at a threshold; pulse density check over a fixed window.
// assumes a one-cycle bit strobe from the same clock domain.
`timescale 1ns/1ps
`include "lcas_map.vh"

module lcas_activity_monitor (
    // clock and reset
    input  wire       core_clk_in,
    input  wire       sys_rst_in,
    // bit stream
    input  wire       bit_stb_in,
    input  wire       pulse_in,
    // configuration
    input  wire [7:0] quiet_limit_in,
    input  wire       density_clear_in,
    // result
    output reg        alarm_out
);

    reg [7:0] quiet_reg;
    reg [7:0] win_reg;
    reg [7:0] ones_reg;

    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            quiet_reg <= 8'h00;
            win_reg   <= 8'h00;
            ones_reg  <= 8'h00;
            alarm_out <= 1'b0;
        end else if (bit_stb_in) begin
            if (pulse_in) begin
                quiet_reg <= 8'h00;
            end else if (quiet_reg != quiet_limit_in) begin
                quiet_reg <= quiet_reg + 8'h01;
            end
            if (win_reg == `LCAS_DENS_WIN - 8'h01) begin
                win_reg  <= 8'h00;
                ones_reg <= 8'h00;
            end else begin
                win_reg  <= win_reg + 8'h01;
                ones_reg <= ones_reg + {7'h00, pulse_in};
            end
            if (!pulse_in && quiet_reg == quiet_limit_in - 8'h01) begin
                alarm_out <= 1'b1;
            end else if (!density_clear_in && pulse_in) begin
                alarm_out <= 1'b0;
            end else if (density_clear_in &&
                         win_reg == `LCAS_DENS_WIN - 8'h01 &&
                         ones_reg + {7'h00, pulse_in} >= `LCAS_DENS_MIN) begin
                alarm_out <= 1'b0;
            end
        end
    end

endmodule // lcas_activity_monitor

// [lcas_channel_alarm.v]
// lcas_channel_alarm.v: one channel's alarm detection, alarm status
// register and transmit control register.
// assumes the processor strobes are synchronous to core_clk_in and the
// line bit strobes are already sampled into the core clock domain.
`timescale 1ns/1ps
`include "lcas_map.vh"

// Functional notes
// - fifo limit alarm set when fill within two bits of overflow/underrun
// - fifo limit alarm drops as soon as fill leaves that margin
// - fifo limit alarm reported only while jitter attenuator enabled
// - status bit 3 shows fifo limit alarm; writes ignored
// - lock lost when recovered clock deviates 5000 ppm or more
// - status bit 2 shows lock lost, read-only
// - signal absent is the E3 detector in E3 mode, else OR of digital and analog detectors
// - status bit 1 shows signal absent, read-only
// - drive monitor alarm after 128 bit periods without bipolar pulse
// - drive monitor alarm clears on renewed bipolar activity
// - drive monitor watches output pads or external monitor pins
// - status bit 0 shows drive monitor alarm, read-only
// - transmit control bits 5,4,2,1,0 read-write; 7,6,3 reserved
// - source bit 0 selects monitor pins, 1 selects output pads
// - rising edge of error-insert bit injects one pattern error
// - digital detector: 160 quiet bits declare, 33% density clears
module lcas_channel_alarm (
    // clock and reset
    input  wire        core_clk_in,
    input  wire        sys_rst_in,
    // processor port
    input  wire [3:0]  cpu_addr_in,
    input  wire [7:0]  cpu_wdata_in,
    input  wire        cpu_wr_in,
    input  wire        cpu_rd_in,
    output reg  [7:0]  cpu_rdata_out,
    // jitter attenuator
    input  wire        ja_enable_in,
    input  wire [5:0]  ja_fill_in,
    input  wire [5:0]  ja_depth_in,
    // receive side
    input  wire        rx_bit_stb_in,
    input  wire        rx_pulse_in,
    input  wire        rx_analog_los_in,
    input  wire        rx_e3_los_in,
    input  wire        rx_e3_mode_in,
    input  wire        rx_clk_tick_in,
    input  wire        ref_clk_tick_in,
    // transmit side pulse views
    input  wire        tx_bit_stb_in,
    input  wire        tx_out_positive_in,
    input  wire        tx_out_negative_in,
    input  wire        monitor_in_positive_in,
    input  wire        monitor_in_negative_in,
    // alarms and controls
    output reg         fifo_limit_alarm_out,
    output reg         clock_lock_lost_out,
    output reg         signal_absent_defect_out,
    output wire        drive_monitor_alarm_out,
    output wire        send_all_ones_out,
    output wire        tx_clock_invert_out,
    output wire        tx_output_level_out,
    output reg         pattern_error_stb_out
);

    reg  [7:0]  channel_transmit_control_reg;
    reg  [5:0]  mon_meta_reg;
    reg  [5:0]  mon_sync_reg;
    reg         err_ins_prev_reg;
    reg  [15:0] ref_cnt_reg;
    reg  [15:0] rx_cnt_reg;
    wire        dlos_alarm;
    wire        mon_pulse;
    wire [7:0]  status_word;
    wire [15:0] rx_cnt_inc;
    wire        ana_los_sync;
    wire        e3_los_sync;
    wire        pad_pos_sync;
    wire        pad_neg_sync;
    wire        mon_pos_sync;
    wire        mon_neg_sync;

    // decoding used by both the read and the write paths
    function is_txctl;
        input [3:0] a;
        begin
            is_txctl = (a == `LCAS_OFS_TXCTL);
        end
    endfunction

    // pins from off-chip pass two flops before any logic reads them
    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mon_meta_reg <= 6'h00;
            mon_sync_reg <= 6'h00;
        end else begin
            mon_meta_reg <= {rx_analog_los_in, rx_e3_los_in,
                             tx_out_positive_in, tx_out_negative_in,
                             monitor_in_positive_in, monitor_in_negative_in};
            mon_sync_reg <= mon_meta_reg;
        end
    end

    // named views of the synchronised pins; only these are read
    assign ana_los_sync = mon_sync_reg[5];
    assign e3_los_sync  = mon_sync_reg[4];
    assign pad_pos_sync = mon_sync_reg[3];
    assign pad_neg_sync = mon_sync_reg[2];
    assign mon_pos_sync = mon_sync_reg[1];
    assign mon_neg_sync = mon_sync_reg[0];

    // register writes; reserved bits stay zero
    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            channel_transmit_control_reg <= `LCAS_TC_RESET;
        end else if (cpu_wr_in && is_txctl(cpu_addr_in)) begin
            channel_transmit_control_reg <=
                cpu_wdata_in & `LCAS_TC_WR_MASK;
        end
    end

    assign tx_output_level_out = channel_transmit_control_reg[`LCAS_TC_LEVEL];
    assign tx_clock_invert_out =
        channel_transmit_control_reg[`LCAS_TC_CLK_INV];
    assign send_all_ones_out = channel_transmit_control_reg[`LCAS_TC_ALL_ONES];

    // single error per rising edge; holding 1 inserts nothing more
    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            err_ins_prev_reg      <= 1'b0;
            pattern_error_stb_out <= 1'b0;
        end else begin
            err_ins_prev_reg <= channel_transmit_control_reg[`LCAS_TC_ERR_INS];
            pattern_error_stb_out <=
                channel_transmit_control_reg[`LCAS_TC_ERR_INS] &
                ~err_ins_prev_reg;
        end
    end

    // fifo margin check, gated by attenuator enable
    // one spare bit so a fill near the top of the fifo cannot wrap
    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fifo_limit_alarm_out <= 1'b0;
        end else begin
            fifo_limit_alarm_out <= ja_enable_in &&
                ((ja_fill_in <= `LCAS_JA_GUARD) ||
                 ({1'b0, ja_fill_in} + {1'b0, `LCAS_JA_GUARD} >=
                  {1'b0, ja_depth_in}));
        end
    end

    // lock check: count recovered ticks over a reference window
    assign rx_cnt_inc = rx_cnt_reg + {15'h0000, rx_clk_tick_in};

    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ref_cnt_reg         <= 16'h0000;
            rx_cnt_reg          <= 16'h0000;
            clock_lock_lost_out <= 1'b0;
        end else if (ref_clk_tick_in &&
                     ref_cnt_reg == `LCAS_LOCK_WIN - 16'h0001) begin
            ref_cnt_reg <= 16'h0000;
            rx_cnt_reg  <= 16'h0000;
            clock_lock_lost_out <=
                (rx_cnt_inc >= `LCAS_LOCK_WIN + `LCAS_LOCK_TOL) ||
                (rx_cnt_inc <= `LCAS_LOCK_WIN - `LCAS_LOCK_TOL);
        end else begin
            ref_cnt_reg <= ref_cnt_reg + {15'h0000, ref_clk_tick_in};
            rx_cnt_reg  <= rx_cnt_inc;
        end
    end

    // digital detector for ds3/sts-1
    lcas_activity_monitor u_dlos (
        .core_clk_in      (core_clk_in),
        .sys_rst_in       (sys_rst_in),
        .bit_stb_in       (rx_bit_stb_in),
        .pulse_in         (rx_pulse_in),
        .quiet_limit_in   (`LCAS_DLOS_BITS),
        .density_clear_in (1'b1),
        .alarm_out        (dlos_alarm)
    );

    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            signal_absent_defect_out <= 1'b0;
        end else begin
            signal_absent_defect_out <= rx_e3_mode_in ? e3_los_sync :
                (dlos_alarm | ana_los_sync);
        end
    end

    // monitor source: pads internally or the external pins
    assign mon_pulse = channel_transmit_control_reg[`LCAS_TC_MON_INT] ?
        (pad_pos_sync | pad_neg_sync) :
        (mon_pos_sync | mon_neg_sync);

    lcas_activity_monitor u_dmo (
        .core_clk_in      (core_clk_in),
        .sys_rst_in       (sys_rst_in),
        .bit_stb_in       (tx_bit_stb_in),
        .pulse_in         (mon_pulse),
        .quiet_limit_in   (`LCAS_DMO_BITS),
        .density_clear_in (1'b0),
        .alarm_out        (drive_monitor_alarm_out)
    );

    // live status, no latching, so reads have no side effect
    assign status_word = {4'h0, fifo_limit_alarm_out, clock_lock_lost_out,
                          signal_absent_defect_out,
                          drive_monitor_alarm_out};

    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cpu_rdata_out <= 8'h00;
        end else if (cpu_rd_in) begin
            if (is_txctl(cpu_addr_in)) begin
                cpu_rdata_out <= channel_transmit_control_reg;
            end else if (cpu_addr_in == `LCAS_OFS_STATUS) begin
                cpu_rdata_out <= status_word;
            end else begin
                cpu_rdata_out <= 8'h00;
            end
        end
    end

endmodule // lcas_channel_alarm

// [lcas_channel_alarm_chk.sv]
// lcas_channel_alarm_chk.sv: port assertions for one channel's alarms.
// assumes every input is driven from the core clock domain.
`timescale 1ns/1ps
`include "lcas_map.vh"

module lcas_channel_alarm_chk (
    // clock, reset and processor port
    input wire       core_clk_in,
    input wire       sys_rst_in,
    input wire [3:0] cpu_addr_in,
    input wire [7:0] cpu_wdata_in,
    input wire       cpu_wr_in,
    input wire       cpu_rd_in,
    input wire [7:0] cpu_rdata_out,
    // detector inputs
    input wire       ja_enable_in,
    input wire [5:0] ja_fill_in,
    input wire [5:0] ja_depth_in,
    input wire       rx_analog_los_in,
    input wire       rx_e3_los_in,
    input wire       rx_e3_mode_in,
    // alarm outputs
    input wire       fifo_limit_alarm_out,
    input wire       signal_absent_defect_out,
    input wire       pattern_error_stb_out
);
    // widened so a fill near the top cannot wrap
    wire near_w = (ja_fill_in <= 6'h02) ||
                  ({1'b0, ja_fill_in} + 7'h02 >= {1'b0, ja_depth_in});
    wire unmap_w = cpu_addr_in != `LCAS_OFS_STATUS &&
                   cpu_addr_in != `LCAS_OFS_TXCTL;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_fifo_near: assert property (ja_enable_in && near_w |=>
        fifo_limit_alarm_out) else $error("fifo alarm missing");
    a_fifo_mid: assert property (ja_enable_in && !near_w |=>
        !fifo_limit_alarm_out) else $error("fifo alarm stuck");
    a_fifo_off: assert property (!ja_enable_in |=>
        !fifo_limit_alarm_out) else $error("fifo alarm while disabled");
    a_los_analog: assert property ((!rx_e3_mode_in && rx_analog_los_in)
        [*4] |-> signal_absent_defect_out) else $error("analog los lost");
    a_los_e3: assert property ((rx_e3_mode_in && rx_e3_los_in) [*4]
        |-> signal_absent_defect_out) else $error("e3 los lost");
    a_err_cause: assert property (pattern_error_stb_out |->
        $past(cpu_wr_in, 2) && $past(cpu_wdata_in[4], 2) &&
        $past(cpu_addr_in, 2) == `LCAS_OFS_TXCTL)
        else $error("error pulse without write");
    a_err_single: assert property (pattern_error_stb_out |=>
        !pattern_error_stb_out) else $error("error pulse too long");
    a_ctl_reserved: assert property (cpu_rd_in &&
        cpu_addr_in == `LCAS_OFS_TXCTL |=> cpu_rdata_out[7:6] == 2'h0 &&
        !cpu_rdata_out[3]) else $error("reserved bits set");
    a_unmapped_zero: assert property (cpu_rd_in && unmap_w |=>
        cpu_rdata_out == 8'h00) else $error("unmapped read not zero");
endmodule // lcas_channel_alarm_chk

bind lcas_channel_alarm lcas_channel_alarm_chk i_chk (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .cpu_addr_in(cpu_addr_in), .cpu_wdata_in(cpu_wdata_in),
    .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in),
    .cpu_rdata_out(cpu_rdata_out), .ja_enable_in(ja_enable_in),
    .ja_fill_in(ja_fill_in), .ja_depth_in(ja_depth_in),
    .rx_analog_los_in(rx_analog_los_in), .rx_e3_los_in(rx_e3_los_in),
    .rx_e3_mode_in(rx_e3_mode_in),
    .fifo_limit_alarm_out(fifo_limit_alarm_out),
    .signal_absent_defect_out(signal_absent_defect_out),
    .pattern_error_stb_out(pattern_error_stb_out));

// [lcas_channel_alarm_tb.sv]
// lcas_channel_alarm_tb.sv: register level tests of one channel's alarms.
// assumes the shared map header and one 40 MHz core clock.
`timescale 1ns/1ps
`include "lcas_map.vh"

module lcas_channel_alarm_tb;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg  [3:0] addr = 4'h0;
    reg  [7:0] wdata = 8'h00;
    reg        wr_en = 1'b0, rd_en = 1'b0, ja_en = 1'b0, rx_on = 1'b0;
    reg        rx_p = 1'b0, ana = 1'b0, e3l = 1'b0, e3m = 1'b0, slow = 1'b0;
    reg        tx_on = 1'b0, pad = 1'b0, mon = 1'b0;
    reg  [5:0] fill = 6'h10;
    reg  [1:0] tk = 2'h0;
    reg  [7:0] rv, errs = 8'h00;
    wire [7:0] rdata;
    wire       fifo_w, lol_w, los_w, dmo_w, ones_w, inv_w, lev_w, err_w;
    integer    num_errors = 0, checks_done = 0, i;

    always #12.5 clk = ~clk;
    always @(posedge clk) tk <= tk + 2'h1;
    // sampled before the edge's own updates land
    always @(posedge clk) if (err_w) errs <= errs + 8'h01;

    lcas_channel_alarm i_lcas_channel_alarm (
        .core_clk_in(clk), .sys_rst_in(rst), .cpu_addr_in(addr),
        .cpu_wdata_in(wdata), .cpu_wr_in(wr_en), .cpu_rd_in(rd_en),
        .cpu_rdata_out(rdata), .ja_enable_in(ja_en), .ja_fill_in(fill),
        .ja_depth_in(6'h20), .rx_bit_stb_in(rx_on), .rx_pulse_in(rx_p),
        .rx_analog_los_in(ana), .rx_e3_los_in(e3l), .rx_e3_mode_in(e3m),
        .rx_clk_tick_in(slow ? tk == 2'h0 : tk[0]), .ref_clk_tick_in(tk[0]),
        .tx_bit_stb_in(tx_on), .tx_out_positive_in(pad),
        .tx_out_negative_in(1'b0), .monitor_in_positive_in(1'b0),
        .monitor_in_negative_in(mon), .fifo_limit_alarm_out(fifo_w),
        .clock_lock_lost_out(lol_w), .signal_absent_defect_out(los_w),
        .drive_monitor_alarm_out(dmo_w), .send_all_ones_out(ones_w),
        .tx_clock_invert_out(inv_w), .tx_output_level_out(lev_w),
        .pattern_error_stb_out(err_w));

    task chk(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED at %0t: got %h want %h",
                         $time, got, exp);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task reg_wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk);
            wr_en <= 1'b1;
            addr <= a;
            wdata <= d;
            @(posedge clk);
            wr_en <= 1'b0;
        end
    endtask
    // read data stands until the next read, so the third edge is safe
    task reg_rd(input [3:0] a);
        begin
            @(posedge clk);
            rd_en <= 1'b1;
            addr <= a;
            @(posedge clk);
            rd_en <= 1'b0;
            @(posedge clk);
            rv = rdata;
        end
    endtask
    task st(input [7:0] m, input [7:0] e);
        begin
            reg_rd(`LCAS_OFS_STATUS);
            chk(rv & m, e);
        end
    endtask
    task final_report;
        begin
            $display("errors %0d checks %0d", num_errors, checks_done);
            if (num_errors == 0 && checks_done > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    initial begin
        cyc(4);
        rst <= 1'b0;
        reg_rd(`LCAS_OFS_TXCTL);
        chk(rv, `LCAS_TC_RESET);
        reg_wr(`LCAS_OFS_TXCTL, 8'hFF);
        reg_rd(`LCAS_OFS_TXCTL);
        chk(rv, 8'h37);
        chk({5'h00, ones_w, inv_w, lev_w}, 8'h07);
        reg_wr(`LCAS_OFS_TXCTL, 8'hFF);
        reg_wr(`LCAS_OFS_TXCTL, 8'h00);
        reg_wr(`LCAS_OFS_TXCTL, 8'h10);
        cyc(3);
        chk(errs, 8'h02);
        reg_wr(`LCAS_OFS_STATUS, 8'hFF);
        st(8'hFF, 8'h00);
        reg_rd(4'h7);
        chk(rv, 8'h00);
        ja_en <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            fill <= (i < 2) ? 6'h02 + i[5:0] : 6'h1B + i[5:0];
            cyc(1);
            st(8'h08, (i == 0 || i == 3) ? 8'h08 : 8'h00);
        end
        chk({7'h00, fifo_w}, 8'h01);
        ja_en <= 1'b0;
        cyc(1);
        st(8'h08, 8'h00);
        ana <= 1'b1;
        cyc(5);
        st(8'h02, 8'h02);
        ana <= 1'b0;
        e3m <= 1'b1;
        e3l <= 1'b1;
        cyc(5);
        st(8'h02, 8'h02);
        e3l <= 1'b0;
        cyc(5);
        st(8'h02, 8'h00);
        e3m <= 1'b0;
        rx_on <= 1'b1;
        cyc(150);
        st(8'h02, 8'h00);
        cyc(12);
        st(8'h02, 8'h02);
        chk({7'h00, los_w}, 8'h01);
        rx_p <= 1'b1;
        cyc(200);
        st(8'h02, 8'h00);
        cyc(8200);
        st(8'h04, 8'h00);
        slow <= 1'b1;
        // a window straddling the change may still pass, so wait for two
        cyc(16100);
        st(8'h04, 8'h04);
        chk({7'h00, lol_w}, 8'h01);
        reg_wr(`LCAS_OFS_TXCTL, 8'h20);
        pad <= 1'b1;
        tx_on <= 1'b1;
        cyc(200);
        st(8'h01, 8'h00);
        reg_wr(`LCAS_OFS_TXCTL, 8'h00);
        cyc(115);
        st(8'h01, 8'h00);
        cyc(25);
        st(8'h01, 8'h01);
        chk({7'h00, dmo_w}, 8'h01);
        st(8'h01, 8'h01);
        mon <= 1'b1;
        cyc(5);
        st(8'h01, 8'h00);
        final_report;
    end

    // whole sequence needs about 25100 cycles
    initial begin
        repeat (40000) @(posedge clk);
        num_errors = num_errors + 1;
        final_report;
    end
endmodule // lcas_channel_alarm_tb
